// >>> logic/sild_defines.vh
// Constants for the serial-in latched driver: timing figures and counts.
// Assumes a single system clock whose period is given below in ns.
//
// What this block does
// [RULE1] Serial data input enters stage one on each shift clock rise.
// [RULE2] Each later rise moves every stage one place toward serial output.
// [RULE3] Host sets the data bit before raising the shift clock.
// [RULE4] While strobe is high each latch takes its shift stage value.
// [RULE5] Latches follow the register for as long as strobe stays high.
// [RULE6] Strobe low holds latches; strobe high, enable low shows live state.
// [RULE7] With strobe tied high the host keeps outputs disabled while shifting.
// [RULE8] Disable high turns all outputs off and leaves all storage alone.
// [RULE9] Output disable low drives each output from its latch.
// [RULE10] Serial data output always shows the eighth stage.
// [RULE11] Without a shift clock rise the register holds all stages.
`ifndef SILD_DEFINES_VH
`define SILD_DEFINES_VH

`define SILD_STAGES         8
`define SILD_CLK_PERIOD_NS  20

// Least times on the pins, in ns as printed.
`define SILD_T_SETUP_NS     75
`define SILD_T_HOLD_NS      75
`define SILD_T_CLK_W_NS     150
`define SILD_T_STB_W_NS     100

// Least times round up to whole system clock cycles.
`define SILD_CEIL_CYC(ns) \
    (((ns) + `SILD_CLK_PERIOD_NS - 1) / `SILD_CLK_PERIOD_NS)
`define SILD_SETUP_CYC      `SILD_CEIL_CYC(`SILD_T_SETUP_NS)
`define SILD_HOLD_CYC       `SILD_CEIL_CYC(`SILD_T_HOLD_NS)
`define SILD_CLK_W_CYC      `SILD_CEIL_CYC(`SILD_T_CLK_W_NS)
`define SILD_STB_W_CYC      `SILD_CEIL_CYC(`SILD_T_STB_W_NS)

`define SILD_CNT_W          8
`define SILD_OUT_OFF        8'h00

`endif

// >>> logic/sild_driver.v
// Serial-in latched driver: eight-stage shift register, eight latches and
// eight sink outputs gated by an active-low enable, plus pin timing checks.
// Assumes all pin inputs come from a host outside the clk_sys domain.
`timescale 1ns/1ps
`include "sild_defines.vh"
module sild_driver #(
    parameter STAGES = `SILD_STAGES
) (
    // Clock and reset
    input  wire              clk_sys,
    input  wire              rstn,
    // Host pins
    input  wire              ser_in,
    input  wire              shift_clk,
    input  wire              strobe,
    input  wire              out_enable_n,
    // Driver outputs, one means the output sinks current
    output reg  [STAGES-1:0] drive_on,
    // Cascade output
    output reg               ser_out,
    // Pin timing checks, one-cycle pulses
    output reg               setup_err,
    output reg               hold_err,
    output reg               clk_width_err,
    output reg               strobe_width_err,
    output reg               bypass_err
);
    // Cycle counts are worked out as integers and cut to the counter width.
    // All of them sit far below the top value of that counter.
    localparam integer SETUP_I = `SILD_SETUP_CYC;
    localparam integer HOLD_I  = `SILD_HOLD_CYC;
    localparam integer CLK_W_I = `SILD_CLK_W_CYC;
    localparam integer STB_W_I = `SILD_STB_W_CYC;
    localparam [`SILD_CNT_W-1:0] SETUP_CYC = SETUP_I[`SILD_CNT_W-1:0];
    localparam [`SILD_CNT_W-1:0] HOLD_CYC  = HOLD_I[`SILD_CNT_W-1:0];
    localparam [`SILD_CNT_W-1:0] CLK_W_CYC = CLK_W_I[`SILD_CNT_W-1:0];
    localparam [`SILD_CNT_W-1:0] STB_W_CYC = STB_W_I[`SILD_CNT_W-1:0];
    localparam [`SILD_CNT_W-1:0] CNT_MAX   = {`SILD_CNT_W{1'b1}};

    // Synchronised pin levels.
    wire [3:0] pins_s;
    wire       data_s;
    wire       sclk_s;
    wire       stb_s;
    wire       dis_s;

    // Previous synchronised levels for edge finding.
    reg        data_q;
    reg        sclk_q;
    reg        stb_q;

    wire       sclk_rise;
    wire       sclk_fall;
    wire       stb_fall;
    wire       data_chg;

    // Storage.
    reg  [STAGES-1:0] shift_reg;
    reg  [STAGES-1:0] latch_q;
    reg  [STAGES-1:0] next_shift;
    reg  [STAGES-1:0] next_latch;

    // Timing counters.
    reg  [`SILD_CNT_W-1:0] data_age;
    reg  [`SILD_CNT_W-1:0] since_rise;
    reg  [`SILD_CNT_W-1:0] clk_high;
    reg  [`SILD_CNT_W-1:0] stb_high;

    function [`SILD_CNT_W-1:0] sat_inc;
        input [`SILD_CNT_W-1:0] v;
        begin
            sat_inc = (v == CNT_MAX) ? v : v + 1'b1;
        end
    endfunction

    // A counter started by one seen pin edge reads one less than the number
    // of clk_sys edges between the two pin events, since both pass the same
    // synchroniser. The compare takes that cycle back off the limit instead
    // of adding it to the count, which could wrap at saturation.
    function too_close;
        input [`SILD_CNT_W-1:0] age;
        input [`SILD_CNT_W-1:0] lim;
        begin
            too_close = (lim != {`SILD_CNT_W{1'b0}}) && (age < lim - 1'b1);
        end
    endfunction

    sild_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       ({out_enable_n, strobe, shift_clk, ser_in}),
        .q       (pins_s)
    );

    assign data_s = pins_s[0];
    assign sclk_s = pins_s[1];
    assign stb_s  = pins_s[2];
    assign dis_s  = pins_s[3];

    // Edge registers reset low like the idle pins, so no edge is seen after
    // reset unless a pin is already high at release.
    assign sclk_rise = sclk_s & ~sclk_q;
    assign sclk_fall = ~sclk_s & sclk_q;
    assign stb_fall  = ~stb_s & stb_q;
    assign data_chg  = data_s ^ data_q;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_q <= 1'b0;
            sclk_q <= 1'b0;
            stb_q  <= 1'b0;
        end else begin
            data_q <= data_s;
            sclk_q <= sclk_s;
            stb_q  <= stb_s;
        end
    end

    // Data and clock pass equal synchroniser delays, so the bit taken is the
    // one that stood in the cycle before the clock rise was seen. This keeps
    // a data change landing together with the rise from slipping in.
    always @* begin
        next_shift = shift_reg; // RULE11
        if (sclk_rise) begin
            next_shift = {shift_reg[STAGES-2:0], data_q}; // RULE1 RULE2
        end
    end

    // The latch follows the register value of this same cycle, so a shift
    // during strobe high reaches the latch without an extra cycle of lag.
    always @* begin
        next_latch = latch_q; // RULE6
        if (stb_s) begin
            next_latch = next_shift; // RULE4 RULE5
        end
    end

    // Output disable only gates the drivers; storage never looks at it.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shift_reg <= {STAGES{1'b0}};
            latch_q   <= {STAGES{1'b0}};
        end else begin
            shift_reg <= next_shift; // RULE8
            latch_q   <= next_latch;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            drive_on <= `SILD_OUT_OFF;
            ser_out  <= 1'b0;
        end else begin
            // Disable acts on the output flop only, so the latch value comes
            // back on the pins as soon as disable drops.
            if (dis_s) begin
                drive_on <= `SILD_OUT_OFF; // RULE8
            end else begin
                drive_on <= next_latch; // RULE9 RULE6
            end
            ser_out <= next_shift[STAGES-1]; // RULE10
        end
    end

    // Age of the present data level, clock high time, time since the last
    // clock rise and strobe high time. All saturate, so long idle gaps are
    // harmless.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_age   <= CNT_MAX;
            since_rise <= CNT_MAX;
            clk_high   <= {`SILD_CNT_W{1'b0}};
            stb_high   <= {`SILD_CNT_W{1'b0}};
        end else begin
            if (data_chg) begin
                data_age <= {`SILD_CNT_W{1'b0}};
            end else begin
                data_age <= sat_inc(data_age);
            end
            if (sclk_rise) begin
                since_rise <= {`SILD_CNT_W{1'b0}};
            end else begin
                since_rise <= sat_inc(since_rise);
            end
            if (sclk_s) begin
                clk_high <= sat_inc(clk_high);
            end else begin
                clk_high <= {`SILD_CNT_W{1'b0}};
            end
            if (stb_s) begin
                stb_high <= sat_inc(stb_high);
            end else begin
                stb_high <= {`SILD_CNT_W{1'b0}};
            end
        end
    end

    // Checks on the host's side of the contract. They only report; the
    // storage path behaves the same whether or not a check fires, since the
    // sampled view of a pin can be one cycle off either way.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            setup_err        <= 1'b0;
            hold_err         <= 1'b0;
            clk_width_err    <= 1'b0;
            strobe_width_err <= 1'b0;
            bypass_err       <= 1'b0;
        end else begin
            // Data that changed too close before the rise.
            setup_err <= sclk_rise & too_close(data_age, SETUP_CYC); // RULE3
            // Data that changed too soon after the rise.
            hold_err <= data_chg & ~sclk_rise & too_close(since_rise, HOLD_CYC);
            // Clock or strobe high for less than its least width.
            clk_width_err <= sclk_fall & (clk_high < CLK_W_CYC);
            strobe_width_err <= stb_fall & (stb_high < STB_W_CYC);
            // Shifting with strobe high and drivers on shows ripple.
            bypass_err <= sclk_rise & stb_s & ~dis_s; // RULE7
        end
    end
endmodule

// >>> logic/sild_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_sys; only q may be read.
`timescale 1ns/1ps
module sild_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rstn,
    // Pins in, synchronised levels out
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= {WIDTH{1'b0}};
            q    <= {WIDTH{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// >>> test/sild_driver_sva.sv
// Checker for the latched driver, sampling its pins on clk_sys.
// Assumes host pins move at most once in two clk_sys cycles.
`timescale 1ns/1ps
module sild_driver_sva #(
    parameter STAGES = 8
) (
    // Clock and reset
    input wire              clk_sys,
    input wire              rstn,
    // Pins
    input wire              ser_in,
    input wire              shift_clk,
    input wire              strobe,
    input wire              out_enable_n,
    input wire [STAGES-1:0] drive_on,
    input wire              ser_out,
    input wire              bypass_err
);
    wire act = strobe && !out_enable_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_first_stage: assert property (
        act [*3] ##0 $rose(shift_clk) ##1 act [*2]
        |-> ##1 drive_on[0] == $past(ser_in, 4))
        else $error("stage one missed the data bit");
    a_chain_step: assert property (
        act [*8] ##1 $changed(drive_on)
        |-> ser_out == $past(drive_on[STAGES-2]))
        else $error("stages did not move one place");
    a_transp_tail: assert property (
        act [*6] |-> drive_on[STAGES-1] == ser_out)
        else $error("transparent latch lost the register");
    a_latch_hold: assert property (
        (!strobe && !out_enable_n) [*5] |-> $stable(drive_on))
        else $error("latch moved with strobe low");
    a_disable_off: assert property (
        out_enable_n [*4] |-> ~|drive_on)
        else $error("output on while disabled");
    a_serout_cause: assert property (
        $changed(ser_out) |-> $past(shift_clk, 3) && !$past(shift_clk, 4))
        else $error("serial out moved without a shift");
    a_clk_hold: assert property (
        !shift_clk [*6] |-> $stable(ser_out))
        else $error("register moved with clock idle");
    a_bypass_flag: assert property (
        act [*3] ##0 $rose(shift_clk) ##1 act [*2] |-> ##[0:3] bypass_err)
        else $error("shift with outputs live not flagged");
    cover property (act ##1 $rose(shift_clk));
    cover property ($fell(out_enable_n));
    cover property ($fell(strobe));
endmodule
bind sild_driver sild_driver_sva #(.STAGES(STAGES)) sild_driver_sva_inst (
    .clk_sys(clk_sys), .rstn(rstn), .ser_in(ser_in), .shift_clk(shift_clk),
    .strobe(strobe), .out_enable_n(out_enable_n), .drive_on(drive_on),
    .ser_out(ser_out), .bypass_err(bypass_err));

// >>> test/sild_driver_tb_top.sv
// Bench for the latched driver: the host model shifts bytes, the bench
// drives strobe and output disable and compares the sink outputs.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
    end end
module sild_driver_tb_top;
    reg        clk_sys = 1'b0;
    reg        rstn = 1'b0;
    reg        strobe = 1'b0;
    reg        out_enable_n = 1'b0;
    reg        host_req = 1'b0;
    reg  [7:0] host_data = 8'h00;
    reg        seen_byp = 1'b0;
    reg  [3:0] seen_tim = 4'h0;
    wire       ser_in, shift_clk, host_done, ser_out, bypass_err;
    wire       setup_err, hold_err, clk_width_err, strobe_width_err;
    wire [7:0] drive_on;
    integer    mismatches = 0;
    integer    checks_done = 0;
    sild_host sild_host_inst (.data(host_data), .req(host_req),
        .done(host_done), .ser_in(ser_in), .shift_clk(shift_clk));
    sild_driver sild_driver_inst (.clk_sys(clk_sys), .rstn(rstn),
        .ser_in(ser_in), .shift_clk(shift_clk), .strobe(strobe),
        .out_enable_n(out_enable_n), .drive_on(drive_on), .ser_out(ser_out),
        .setup_err(setup_err), .hold_err(hold_err),
        .clk_width_err(clk_width_err), .strobe_width_err(strobe_width_err),
        .bypass_err(bypass_err));
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (bypass_err) seen_byp <= 1'b1;
        seen_tim <= seen_tim | {setup_err, hold_err, clk_width_err,
            strobe_width_err};
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task send(input [7:0] b);
        integer n;
        host_data <= b;
        host_req <= 1'b1;
        @(posedge clk_sys);
        for (n = 0; n < 200 && host_done !== 1'b1; n++) @(posedge clk_sys);
        if (host_done !== 1'b1) mismatches++;
        host_req <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task set_pins(input s, input d);
        strobe <= s;
        out_enable_n <= d;
        repeat (8) @(posedge clk_sys);
    endtask
    task t_latch;
        send(8'ha5);
        `CHK(drive_on, 8'h00)
        `CHK(ser_out, 1'b1)
        set_pins(1'b1, 1'b0);
        set_pins(1'b0, 1'b0);
        `CHK(drive_on, 8'ha5)
        $display("t_latch done");
    endtask
    task t_hold_disable;
        send(8'h3c);
        `CHK(drive_on, 8'ha5)
        set_pins(1'b0, 1'b1);
        `CHK(drive_on, 8'h00)
        set_pins(1'b0, 1'b0);
        `CHK(drive_on, 8'ha5)
        set_pins(1'b1, 1'b0);
        set_pins(1'b0, 1'b0);
        `CHK(drive_on, 8'h3c)
        $display("t_hold_disable done");
    endtask
    task t_bypass;
        set_pins(1'b1, 1'b1);
        send(8'h81);
        `CHK(drive_on, 8'h00)
        `CHK(seen_byp, 1'b0)
        set_pins(1'b1, 1'b0);
        `CHK(drive_on, 8'h81)
        send(8'h5a);
        `CHK(drive_on, 8'h5a)
        `CHK(seen_byp, 1'b1)
        set_pins(1'b0, 1'b0);
        $display("t_bypass done");
    endtask
    task t_timing;
        send(8'hc3);
        `CHK(drive_on, 8'h5a)
        strobe <= 1'b1;
        repeat (2) @(posedge clk_sys);
        strobe <= 1'b0;
        repeat (8) @(posedge clk_sys);
        `CHK(drive_on, 8'hc3)
        `CHK(seen_tim, 4'h3)
        $display("t_timing done");
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_latch;
        t_hold_disable;
        t_bypass;
        t_timing;
        wrap_up;
    end
    initial begin
        #100000;
        mismatches++;
        wrap_up;
    end
endmodule

// >>> test/sild_host.sv
// Host model: shifts one byte, first bit first, on each rise of req.
// Assumes req stays high until done; pins move off the clk_sys grid.
`timescale 1ns/1ps
module sild_host (
    // Request from the bench
    input  wire [7:0] data,
    input  wire       req,
    output reg        done,
    // Pins to the driver
    output reg        ser_in,
    output reg        shift_clk
);
    integer i;
    initial begin
        done = 1'b0;
        ser_in = 1'b0;
        shift_clk = 1'b0;
    end
    // The odd offset keeps the link edges away from clk_sys edges.
    always @(posedge req) begin
        done = 1'b0;
        #7;
        for (i = 7; i >= 0; i = i - 1) begin
            ser_in = data[i];
            #80 shift_clk = 1'b1;
            #80 shift_clk = 1'b0;
        end
        done = 1'b1;
    end
endmodule
